// ===== design/mie_pkg.sv
// Package with register map, field positions and reset values of the interrupt block.
package mie_pkg;
   // Register indices; the Wishbone byte address is four times the index.
   localparam logic [5:0] IDX_BUS_PIN_CTRL = 6'h30;
   localparam logic [5:0] IDX_EDGE_SELECT  = 6'h3a;
   localparam logic [5:0] IDX_REQUEST_ONE  = 6'h3c;
   localparam logic [5:0] IDX_REQUEST_TWO  = 6'h3d;
   localparam logic [5:0] IDX_ENABLE_ONE   = 6'h3e;

   // Writable bit masks; all other bits read as zero.
   localparam logic [7:0] EDGE_SELECT_MASK = 8'h0f;
   localparam logic [7:0] REQUEST_TWO_MASK = 8'h7f;
   localparam logic [7:0] BUS_PIN_MASK     = 8'h60;

   // Field positions in the bus pin control register.
   localparam int BUS_PIN_POLARITY_BIT = 5;
   localparam int BUS_PIN_SELECT_BIT   = 6;

   // Bit positions shared by the enable and first request registers.
   localparam int EN_EXT_ZERO  = 0;
   localparam int EN_BUS_PIN   = 1;
   localparam int EN_EXT_ONE   = 2;
   localparam int EN_EXT_TWO   = 3;
   localparam int EN_EXT_THREE = 4;

   localparam int NUM_EDGE_PINS = 5;

   localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// ===== design/mie_edge_if.sv
// Interface carrying one pin, its polarity and the detected edge pulse.
`timescale 1ns/100ps
interface mie_edge_if;
   logic pin;
   logic rising;
   logic pulse;
   modport ctrl (output pin, output rising, input pulse);
   modport det  (input pin, input rising, output pulse);
endinterface

// ===== design/mie_edge_detect.sv
// Synchroniser and selectable edge detector for one interrupt pin.
`timescale 1ns/100ps
module mie_edge_detect (
   input  wire logic i_ref_clk,
   input  wire logic i_sys_rst,
   mie_edge_if.det   edge_port
);
   import mie_pkg::*;

   logic sync1_q, sync2_q, prev_q, pulse_q;
   logic sync1_d, sync2_d, prev_d, pulse_d;

   always_comb begin
      sync1_d = edge_port.pin;
      sync2_d = sync1_q;
      prev_d  = sync2_q;
      // A rising edge is taken when polarity is 1, a falling edge when 0.
      pulse_d = edge_port.rising ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         prev_q  <= prev_d;
         pulse_q <= pulse_d;
      end
   end

   assign edge_port.pulse = pulse_q;
endmodule

// ===== design/mie_irq_regs.sv
// Interrupt edge select, request and enable registers behind a Wishbone slave.
`timescale 1ns/100ps
// What this block does
// - Edge select bits 0-3, 1 rising, reset 0
// - Edge select bits 4-7 ignore writes, read zero
// - Request two holds seven source flags, bits 0-6
// - Flag reads 1 while pending, resets to 0
// - Request two bit 7 reads zero, unwritable
// - Enable one holds eight source enable bits
// - Enable bit 1 enables, read/write, reset 0
// - Select bit routes SDA or SCL to interrupt
// - Polarity bit picks falling or rising bus edge
module mie_irq_regs (
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [3:0]  i_ext_pin,
   input  wire logic        i_scl_pin,
   input  wire logic        i_sda_pin,
   input  wire logic [2:0]  i_src_req_one,
   input  wire logic [6:0]  i_src_req_two,
   output logic      [7:0]  o_irq,
   output logic      [6:0]  o_req_two_pending
);
   import mie_pkg::*;

   logic [7:0]  edge_sel_q, edge_sel_d;
   logic [7:0]  bus_ctrl_q, bus_ctrl_d;
   logic [7:0]  req_one_q, req_one_d;
   logic [7:0]  req_two_q, req_two_d;
   logic [7:0]  enable_q, enable_d;
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic [7:0]  irq_q, irq_d;
   logic [6:0]  pend_q, pend_d;
   logic [5:0]  idx;
   logic        wr_byte;
   logic [7:0]  rd_byte;
   logic [7:0]  set_one;
   logic [NUM_EDGE_PINS-1:0] edge_pulse;

   mie_edge_if edge_bus [NUM_EDGE_PINS] ();

   // Pins 0-3 are the external lines, pin 4 the selected two-wire line.
   // Changing source select can raise one spurious edge; clear the flag after.
   generate
      for (genvar g = 0; g < NUM_EDGE_PINS; g++) begin : g_edge
         if (g < 4) begin : g_ext
            assign edge_bus[g].pin    = i_ext_pin[g];
            assign edge_bus[g].rising = edge_sel_q[g];
         end else begin : g_bus
            assign edge_bus[g].pin    = bus_ctrl_q[BUS_PIN_SELECT_BIT] ? i_scl_pin
                                                                      : i_sda_pin;
            assign edge_bus[g].rising = bus_ctrl_q[BUS_PIN_POLARITY_BIT];
         end
         assign edge_pulse[g] = edge_bus[g].pulse;
         mie_edge_detect u_edge (
            .i_ref_clk (i_ref_clk),
            .i_sys_rst (i_sys_rst),
            .edge_port (edge_bus[g])
         );
      end
   endgenerate

   // Only the low byte lane carries register data; address bits 1:0 are ignored.
   assign idx     = i_wb_adr[7:2];
   // A write lands on the edge where the master sees ack high.
   assign wr_byte = i_wb_cyc & i_wb_stb & i_wb_we & ack_q & i_wb_sel[0];

   // Request one gathers pin edges in bits 0-4 and peripheral strobes in bits 5-7.
   always_comb begin
      set_one               = {i_src_req_one, 5'h00};
      set_one[EN_EXT_ZERO]  = edge_pulse[0];
      set_one[EN_EXT_ONE]   = edge_pulse[1];
      set_one[EN_EXT_TWO]   = edge_pulse[2];
      set_one[EN_EXT_THREE] = edge_pulse[3];
      set_one[EN_BUS_PIN]   = edge_pulse[4];
   end

   // Configuration registers change only on a write at the ack edge.
   always_comb begin
      edge_sel_d = edge_sel_q;
      bus_ctrl_d = bus_ctrl_q;
      enable_d   = enable_q;
      if (wr_byte) begin
         case (idx)
            IDX_EDGE_SELECT: begin
               edge_sel_d = i_wb_dat[7:0] & EDGE_SELECT_MASK;
            end
            IDX_BUS_PIN_CTRL: begin
               bus_ctrl_d = i_wb_dat[7:0] & BUS_PIN_MASK;
            end
            IDX_ENABLE_ONE: begin
               enable_d = i_wb_dat[7:0];
            end
            default: begin
               enable_d = enable_q;
            end
         endcase
      end
   end

   // Source events are merged every cycle, so a strobe is never lost to a write.
   always_comb begin
      req_one_d = req_one_q | set_one;
      req_two_d = (req_two_q | {1'b0, i_src_req_two}) & REQUEST_TWO_MASK;
      if (wr_byte) begin
         case (idx)
            IDX_REQUEST_ONE: begin
               // Zero bits clear, but a simultaneous event keeps the flag set.
               req_one_d = (req_one_q & i_wb_dat[7:0]) | set_one;
            end
            IDX_REQUEST_TWO: begin
               req_two_d = ((req_two_q & i_wb_dat[7:0]) | {1'b0, i_src_req_two})
                           & REQUEST_TWO_MASK;
            end
            default: begin
               req_one_d = req_one_q | set_one;
            end
         endcase
      end
   end

   // Unmapped indices read as zero and are still acknowledged, so software never stalls.
   always_comb begin
      case (idx)
         IDX_EDGE_SELECT:  rd_byte = edge_sel_q;
         IDX_BUS_PIN_CTRL: rd_byte = bus_ctrl_q;
         IDX_REQUEST_ONE:  rd_byte = req_one_q;
         IDX_REQUEST_TWO:  rd_byte = req_two_q;
         IDX_ENABLE_ONE:   rd_byte = enable_q;
         default:          rd_byte = 8'h00;
      endcase
      ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
      dat_d  = ack_d ? {24'h00_0000, rd_byte} : 32'h0000_0000;
   end

   // Interrupt lines to the core follow flags and enables one cycle later.
   always_comb begin
      irq_d  = req_one_q & enable_q;
      pend_d = req_two_q[6:0];
   end

   // Edge polarity of the four external pins.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         edge_sel_q <= REG_RESET;
      end else begin
         edge_sel_q <= edge_sel_d;
      end
   end

   // Source select and polarity of the two-wire line interrupt.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bus_ctrl_q <= REG_RESET;
      end else begin
         bus_ctrl_q <= bus_ctrl_d;
      end
   end

   // Pin and peripheral request flags of the first request register.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         req_one_q <= REG_RESET;
      end else begin
         req_one_q <= req_one_d;
      end
   end

   // Peripheral request flags of the second request register.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         req_two_q <= REG_RESET;
      end else begin
         req_two_q <= req_two_d;
      end
   end

   // Source enables of the first enable register.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         enable_q <= REG_RESET;
      end else begin
         enable_q <= enable_d;
      end
   end

   // Bus answer: one acknowledge pulse with its read data.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // Registered interrupt and pending outputs.
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_q  <= 8'h00;
         pend_q <= 7'h00;
      end else begin
         irq_q  <= irq_d;
         pend_q <= pend_d;
      end
   end

   assign o_wb_ack          = ack_q;
   assign o_wb_dat          = dat_q;
   assign o_irq             = irq_q;
   assign o_req_two_pending = pend_q;
endmodule

// ===== tb/mie_irq_regs_assertions.sv
// Bus timing and request flag checker for the interrupt register block.
`timescale 1ns/100ps
module mie_irq_regs_chk
   import mie_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_sys_rst,
   input wire logic        i_wb_cyc,
   input wire logic        i_wb_stb,
   input wire logic        i_wb_we,
   input wire logic [7:0]  i_wb_adr,
   input wire logic [31:0] o_wb_dat,
   input wire logic        o_wb_ack,
   input wire logic [6:0]  i_src_req_two,
   input wire logic [6:0]  o_req_two_pending
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic rd_ack = o_wb_ack && !i_wb_we;
   ack_one_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack held longer than one cycle");
   ack_next_cycle_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("request not answered in one cycle");
   idle_data_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data not zero without ack");
   upper_data_zero_a: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   edge_high_zero_a: assert property (
      rd_ack && i_wb_adr[7:2] == IDX_EDGE_SELECT |-> o_wb_dat[7:4] == 4'h0)
      else $error("edge select upper bits not zero");
   request_top_zero_a: assert property (
      rd_ack && i_wb_adr[7:2] == IDX_REQUEST_TWO |-> !o_wb_dat[7])
      else $error("request bit 7 not zero");
   pend_set_a: assert property (|i_src_req_two |-> ##2 ((o_req_two_pending &
      $past(i_src_req_two, 2)) == $past(i_src_req_two, 2))) else $error("flag not set");
   pend_rise_cause_a: assert property ((o_req_two_pending & ~$past(o_req_two_pending) &
      ~$past(i_src_req_two, 2)) == 7'h00) else $error("flag set without strobe");
   pend_clear_cause_a: assert property (|($past(o_req_two_pending) & ~o_req_two_pending)
      |-> $past(o_wb_ack, 2) && $past(i_wb_we, 2)) else $error("flag cleared without write");
   cover property (o_wb_ack && i_wb_we);
   cover property (rd_ack);
   cover property (o_req_two_pending == 7'h7f);
endmodule
bind mie_irq_regs mie_irq_regs_chk u_chk (.*);

// ===== tb/mie_src_model.sv
// Peripheral request strobes and pin levels on the far side of the block.
`timescale 1ns/100ps
module mie_src_model (
   input  wire logic       i_ref_clk,
   output logic      [3:0] o_ext_pin,
   output logic            o_scl_pin,
   output logic            o_sda_pin,
   output logic      [2:0] o_req_one,
   output logic      [6:0] o_req_two
);
   // Two-wire lines rest high on their pull-ups, external pins rest low.
   initial {o_ext_pin, o_scl_pin, o_sda_pin, o_req_one, o_req_two} = 16'h0c00;
   task fire(input logic [2:0] one, input logic [6:0] two);
      @(posedge i_ref_clk);
      o_req_one <= one;
      o_req_two <= two;
      @(posedge i_ref_clk);
      o_req_one <= 3'h0;
      o_req_two <= 7'h00;
   endtask
   task pins(input logic [3:0] ext, input logic scl, input logic sda);
      @(posedge i_ref_clk);
      o_ext_pin <= ext;
      o_scl_pin <= scl;
      o_sda_pin <= sda;
   endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the interrupt register block.
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00, q, irq;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic        ack, scl, sda;
   logic [3:0]  ext;
   logic [2:0]  r1;
   logic [6:0]  r2, pend;
   int          errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   mie_irq_regs dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_ext_pin(ext), .i_scl_pin(scl), .i_sda_pin(sda),
      .i_src_req_one(r1), .i_src_req_two(r2), .o_irq(irq), .o_req_two_pending(pend));
   mie_src_model src (.i_ref_clk(clk), .o_ext_pin(ext), .o_scl_pin(scl), .o_sda_pin(sda),
      .o_req_one(r1), .o_req_two(r2));
   task summarize;
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         errors++;
      end
   endtask
   // One classic cycle; the request is held until the edge that samples ack.
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr} <= {2'b11, w, a};
      wdat <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         $display("wrong value ack expected 1 seen %b", ack);
         errors++;
         summarize();
      end
      q = rdat[7:0];
      {cyc, stb, we} <= 3'b000;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk("register", e, q);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(8'he8, 8'h00);
      rd(8'hf4, 8'h00);
      rd(8'hf8, 8'h00);
      acc(1'b1, 8'he8, 8'hef);
      rd(8'he8, 8'h0f);
      acc(1'b1, 8'hf8, 8'hff);
      rd(8'hf8, 8'hff);
      src.fire(3'h7, 7'h7f);
      repeat (3) @(negedge clk);
      chk("pending", 32'h0000_007f, pend);
      chk("irq", 32'h0000_00e0, irq);
      rd(8'hf4, 8'h7f);
      acc(1'b1, 8'hf4, 8'hff);
      rd(8'hf4, 8'h7f);
      acc(1'b1, 8'hf4, 8'h7e);
      rd(8'hf4, 8'h7e);
      acc(1'b1, 8'hf8, 8'h1f);
      repeat (2) @(negedge clk);
      chk("irq", 32'h0000_0000, irq);
      src.pins(4'h1, 1'b1, 1'b1);
      repeat (8) @(negedge clk);
      chk("irq", 32'h0000_0001, irq);
      acc(1'b1, 8'hc0, 8'h40);
      src.pins(4'h1, 1'b1, 1'b0);
      repeat (8) @(negedge clk);
      chk("irq", 32'h0000_0001, irq);
      src.pins(4'h1, 1'b0, 1'b0);
      repeat (8) @(negedge clk);
      chk("irq", 32'h0000_0003, irq);
      acc(1'b1, 8'hc0, 8'h60);
      rd(8'hc0, 8'h60);
      acc(1'b1, 8'hf0, 8'hfd);
      rd(8'hf0, 8'he1);
      chk("irq", 32'h0000_0001, irq);
      src.pins(4'h1, 1'b1, 1'b0);
      repeat (8) @(negedge clk);
      chk("irq", 32'h0000_0003, irq);
      src.pins(4'hf, 1'b1, 1'b0);
      repeat (8) @(negedge clk);
      chk("irq", 32'h0000_001f, irq);
      rd(8'hf0, 8'hff);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("irq", 32'h0000_0000, irq);
      chk("pending", 32'h0000_0000, pend);
      rd(8'hf0, 8'h00);
      rd(8'hf4, 8'h00);
      rd(8'hf8, 8'h00);
      rd(8'he8, 8'h00);
      rd(8'hc0, 8'h00);
      rd(8'h00, 8'h00);
      summarize();
   end
endmodule
